// ### design/pss_switcher.sv
// What this block does
// - Code space is eight equal slots of 2 kbytes, 16 kbytes in all, one program per slot.
// - After any reset execution starts in slot zero.
// - A chosen slot stays active until another jump or a reset.
// - A jump starts the target slot at its first instruction.
// - A jump keeps no return address, so the caller cannot be resumed.
// - Pin directions and output latches are untouched by a jump.
// - Variable and scratch-pad RAM are untouched by a jump.
// - Slot numbers above seven wrap modulo eight.
// - The active slot number reads back at scratch-pad location 63.
// - The jump operand is a run-time value nominally zero to seven.
module pss_switcher
	import pss_pkg::*;
#(
	parameter int SWITCH_CYCLES = SWITCH_CYC
)(
	// clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 rst_b,
	input  wire logic                 clk_en,
	// jump command from the core
	input  wire logic                 jump_req,
	input  wire logic [15:0]          jump_slot,
	output logic                      jump_busy,
	// program counter within slot
	input  wire logic [OFS_W-1:0]     pc_ofs,
	output logic                      pc_restart,
	output logic                      exec_en,
	output logic [ADDR_W-1:0]         code_addr,
	// scratch-pad read path
	input  wire logic [SP_ADDR_W-1:0] sp_rd_addr,
	input  wire logic [7:0]           sp_mem_data,
	output logic [7:0]                sp_rd_data,
	// current slot
	output logic [SLOT_W-1:0]         cur_slot
);
	pss_state_t       state_r, state_nxt;
	logic [SLOT_W-1:0] slot_r, slot_nxt;
	logic [CNT_W-1:0]  cnt_r, cnt_nxt;
	logic              restart_r, restart_nxt;

	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SWITCH_CYCLES - 1);

	always_comb begin
		state_nxt   = state_r;
		slot_nxt    = slot_r;
		cnt_nxt     = cnt_r;
		restart_nxt = 1'b0;
		case (state_r)
			PSS_RUN: begin
				if (jump_req) begin
					// low bits only: wraps modulo eight
					slot_nxt  = jump_slot[SLOT_W-1:0];
					cnt_nxt   = '0;
					state_nxt = PSS_SWITCH; // no return address kept
				end
			end
			PSS_SWITCH: begin
				if (cnt_r == CNT_LAST) begin
					state_nxt   = PSS_START; // fixed latency
					restart_nxt = 1'b1;
				end else begin
					cnt_nxt = cnt_r + CNT_W'(1);
				end
			end
			PSS_START: begin
				state_nxt = PSS_RUN; // target slot runs until next jump
			end
			default: begin
				state_nxt = PSS_RUN;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			state_r   <= PSS_RUN;
			slot_r    <= RESET_SLOT;
			cnt_r     <= '0;
			restart_r <= 1'b1;
		end else if (clk_en) begin
			state_r   <= state_nxt;
			slot_r    <= slot_nxt;
			cnt_r     <= cnt_nxt;
			restart_r <= restart_nxt;
		end
	end

	// pins, latches and RAM live outside; nothing here touches them
	assign jump_busy  = (state_r != PSS_RUN);
	assign exec_en    = (state_r == PSS_RUN) && !restart_r;
	assign pc_restart = restart_r; // start at offset zero
	assign cur_slot   = slot_r;

	// slot number overlays location 63
	always_comb begin
		if (sp_rd_addr == SP_SLOT_LOC) begin
			sp_rd_data = {5'h00, slot_r};
		end else begin
			sp_rd_data = sp_mem_data;
		end
	end

	pss_slot_addr u_addr (
		.slot      (slot_r),
		.ofs       (restart_r ? '0 : pc_ofs),
		.code_addr (code_addr)
	);
endmodule

// ### design/pss_pkg.sv
package pss_pkg;
	localparam int SLOT_CNT          = 8;
	localparam int SLOT_W            = 3;
	localparam int SLOT_BYTES        = 2048;
	localparam int CODE_BYTES        = SLOT_CNT * SLOT_BYTES;
	localparam int OFS_W             = 11;
	localparam int ADDR_W            = 14;
	localparam int SP_ADDR_W         = 6;
	localparam logic [5:0] SP_SLOT_LOC = 6'h3F;
	localparam logic [2:0] RESET_SLOT  = 3'h0;
	localparam int CLK_MHZ           = 100;
	localparam int SWITCH_US         = 300;
	localparam int SWITCH_CYC        = SWITCH_US * CLK_MHZ;
	localparam int CNT_W             = 16;

	typedef enum logic [1:0] {
		PSS_RUN    = 2'b00,
		PSS_SWITCH = 2'b01,
		PSS_START  = 2'b10
	} pss_state_t;
endpackage

// ### design/pss_slot_addr.sv
module pss_slot_addr
	import pss_pkg::*;
(
	// slot and offset
	input  wire logic [SLOT_W-1:0] slot,
	input  wire logic [OFS_W-1:0]  ofs,
	// code memory address
	output logic      [ADDR_W-1:0] code_addr
);
	assign code_addr = {slot, ofs};
endmodule

// ### test/pss_switcher_props.sv
module pss_props
	import pss_pkg::*;
#(parameter int SWITCH_CYCLES = 4)(
	input wire logic core_clk, rst_b, clk_en, jump_req, jump_busy, pc_restart, exec_en,
	input wire logic [15:0] jump_slot,
	input wire logic [OFS_W-1:0] pc_ofs,
	input wire logic [ADDR_W-1:0] code_addr,
	input wire logic [5:0] sp_rd_addr,
	input wire logic [7:0] sp_mem_data, sp_rd_data,
	input wire logic [2:0] cur_slot
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	wire tk = clk_en && jump_req && !jump_busy;
	a_slot_wrap: assert property (tk |=> cur_slot == 3'($past(jump_slot))) else $error("slot");
	a_reset_slot: assert property (disable iff (1'b0) !rst_b && clk_en
		|=> cur_slot == 3'h0 && pc_restart && !exec_en) else $error("reset");
	a_switch_time: assert property (tk |=> jump_busy && !exec_en ##SWITCH_CYCLES
		pc_restart && code_addr == {cur_slot, 11'h0}) else $error("switch");
	a_restart_pulse: assert property (pc_restart && clk_en |=> !pc_restart) else $error("pulse");
	a_run_after: assert property (pc_restart && clk_en && !tk |=> exec_en && !jump_busy)
		else $error("run");
	a_slot_hold: assert property (rst_b && !tk |=> $stable(cur_slot)) else $error("hold");
	a_busy_idle: assert property (jump_busy |-> !exec_en) else $error("exec");
	a_addr_map: assert property (!pc_restart |-> code_addr == {cur_slot, pc_ofs}) else $error("addr");
	a_sp_slot: assert property (sp_rd_addr == SP_SLOT_LOC |-> sp_rd_data == {5'h0, cur_slot})
		else $error("sp");
	c_wrap: cover property (tk && jump_slot[3]);
	c_refuse: cover property (jump_busy && jump_req);
	c_restart: cover property (pc_restart && exec_en == 1'b0);
endmodule
bind pss_switcher pss_props #(.SWITCH_CYCLES(SWITCH_CYCLES)) u_props (.*);

// ### test/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 0, rst_b = 0, jump_req = 0, jump_busy, pc_restart, exec_en;
	logic clk_en = 1, m_rst = 1;
	logic [15:0] jump_slot = 16'h0;
	logic [10:0] pc_ofs = 11'h0;
	logic [5:0] sp_rd_addr = 6'h0;
	logic [7:0] sp_mem_data = 8'h0, sp_rd_data;
	logic [13:0] code_addr;
	logic [2:0] cur_slot, m_slot = 3'h0;
	int errors = 0, num_checks = 0, cyc = 0, m_cnt = 0, seed = 32'h33ada4f2;
	always #5 core_clk = ~core_clk;
	pss_switcher #(.SWITCH_CYCLES(4)) dut (.core_clk, .rst_b, .clk_en, .jump_req,
		.jump_slot, .jump_busy, .pc_ofs, .pc_restart, .exec_en, .code_addr, .sp_rd_addr,
		.sp_mem_data, .sp_rd_data, .cur_slot);
	task automatic chk(logic [15:0] got, logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic complete_run;
		if (errors == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge core_clk) begin
		if (!rst_b) begin
			m_slot = 3'h0;
			m_cnt = 0;
			m_rst = 1'b1;
		end else if (clk_en) begin
			if (m_cnt > 0) m_cnt--;
			else if (jump_req) begin
				m_slot = 3'(jump_slot % 8);
				m_cnt = 5;
			end
			m_rst = (m_cnt == 1);
		end
		if (++cyc > 3000) begin
			errors++;
			complete_run;
		end
	end
	always @(negedge core_clk) if (rst_b) begin
		chk(cur_slot, m_slot);
		chk(jump_busy, m_cnt != 0);
		chk(pc_restart, m_rst);
		chk(exec_en, m_cnt == 0 && !m_rst);
		chk(code_addr, {m_slot, m_rst ? 11'h000 : pc_ofs});
		if (sp_rd_addr == 6'h3F) chk(sp_rd_data, m_slot);
		else chk(sp_rd_data, sp_mem_data);
	end
	initial begin
		repeat (16) @(posedge core_clk);
		for (int i = 0; i < 800; i++) begin
			@(posedge core_clk);
			rst_b <= i != 400;
			jump_req <= (i < 590 || i > 700) && $random(seed) % 4 == 0;
			clk_en <= (i < 600 || i > 700) || i[2];
			jump_slot <= $random(seed);
			pc_ofs <= $random(seed);
			sp_rd_addr <= i[0] ? 6'h3F : 6'($random(seed));
			sp_mem_data <= $random(seed);
		end
		complete_run;
	end
endmodule
